// >>> inc/smp_pkg.sv
/*
  shared constants of the scan master host port: register select codes,
  field positions, reset values, masks and host strobe timing.
  assumes a single core clock of 40 MHz shared by both ends.
*/
package smp_pkg;

  // register select codes seen on the three select lines
  localparam logic [2:0] SMP_SEL_CFG_PRI  = 3'h0;
  localparam logic [2:0] SMP_SEL_CFG_SEC  = 3'h1;
  localparam logic [2:0] SMP_SEL_FLAGS    = 3'h2;
  localparam logic [2:0] SMP_SEL_OPREQ    = 3'h3;
  localparam logic [2:0] SMP_SEL_OUTBOUND = 3'h4;
  localparam logic [2:0] SMP_SEL_INBOUND  = 3'h5;
  localparam logic [2:0] SMP_SEL_COUNT    = 3'h6;
  localparam logic [2:0] SMP_SEL_MANUAL   = 3'h7;

  // reset values
  localparam logic [7:0] SMP_RST_CFG_PRI  = 8'h00;
  localparam logic [7:0] SMP_RST_CFG_SEC  = 8'h80;
  localparam logic [7:0] SMP_RST_OPREQ    = 8'h00;
  localparam logic [7:0] SMP_RST_OUTBOUND = 8'h00;
  localparam logic [7:0] SMP_RST_COUNT    = 8'h00;
  localparam logic [7:0] SMP_RST_MANUAL   = 8'h00;

  // writable bits; reserved positions store nothing and read zero
  localparam logic [7:0] SMP_MASK_CFG_PRI = 8'h3F;
  localparam logic [7:0] SMP_MASK_CFG_SEC = 8'hEF;
  localparam logic [7:0] SMP_MASK_MANUAL  = 8'h0F;

  // field positions
  localparam int SMP_FLAG_IN_EMPTY_BIT  = 7;
  localparam int SMP_FLAG_OUT_FULL_BIT  = 6;
  localparam int SMP_SOFT_RESET_BIT     = 7;
  localparam int SMP_OPCODE_MSB         = 3;
  localparam int SMP_RDLY_MSB           = 3;
  localparam int SMP_HOST_READ_BIT      = 7;

  // outbound writes may lead inbound reads by this many bytes
  localparam logic [3:0] SMP_LOOKAHEAD_LIMIT = 4'h5;

  // host controller register offsets and irq bits
  localparam logic [2:0] SMP_H_TARGET   = 3'h0;
  localparam logic [2:0] SMP_H_WDATA    = 3'h1;
  localparam logic [2:0] SMP_H_GO       = 3'h2;
  localparam logic [2:0] SMP_H_RDATA    = 3'h3;
  localparam logic [2:0] SMP_H_STATUS   = 3'h4;
  localparam logic [2:0] SMP_H_IRQ_STAT = 3'h5;
  localparam logic [2:0] SMP_H_IRQ_MASK = 3'h6;
  localparam int SMP_IRQ_DONE_BIT  = 0;
  localparam int SMP_IRQ_STALL_BIT = 1;

  // host strobe timing in ns, and least cycle counts derived from them
  localparam int SMP_CLK_PERIOD_NS = 25;
  localparam int SMP_SETUP_NS      = 50;
  localparam int SMP_STROBE_LOW_NS = 300;
  localparam int SMP_HOLD_NS       = 100;
  localparam int SMP_RECOVER_NS    = 200;
  localparam int SMP_SETUP_CYC   = (SMP_SETUP_NS + SMP_CLK_PERIOD_NS - 1) / SMP_CLK_PERIOD_NS;
  localparam int SMP_LOW_CYC     = (SMP_STROBE_LOW_NS + SMP_CLK_PERIOD_NS - 1) / SMP_CLK_PERIOD_NS;
  localparam int SMP_HOLD_CYC    = (SMP_HOLD_NS + SMP_CLK_PERIOD_NS - 1) / SMP_CLK_PERIOD_NS;
  localparam int SMP_RECOVER_CYC = (SMP_RECOVER_NS + SMP_CLK_PERIOD_NS - 1) / SMP_CLK_PERIOD_NS;

endpackage

// >>> inc/smp_if.sv
/*
  pins between the host and the scan master host port.
  assumes nothing else drives the data bus; an idle bus reads all ones.
*/
`timescale 1ns/10ps
interface smp_if;
  logic       access_strobe_n;
  logic       read_select;
  logic [2:0] register_select;
  logic [7:0] host_data_out;
  logic       host_data_oe_n;
  logic [7:0] device_data_out;
  logic       device_data_oe_n;
  logic       grant;
  logic [7:0] host_data_bus;

  // resolved level of the shared bus, device drive first
  assign host_data_bus = !device_data_oe_n ? device_data_out :
                         (!host_data_oe_n ? host_data_out : 8'hFF);

  modport device (
    input  access_strobe_n,
    input  read_select,
    input  register_select,
    input  host_data_bus,
    output device_data_out,
    output device_data_oe_n,
    output grant
  );

  modport host (
    output access_strobe_n,
    output read_select,
    output register_select,
    output host_data_out,
    output host_data_oe_n,
    input  host_data_bus,
    input  grant
  );
endinterface

// >>> hw/smp_sync.sv
/*
  three stage synchroniser with agreement filter for a group of pins.
  assumes each bit is a level; the filtered value moves only when the
  second and third stages agree.
*/
`timescale 1ns/10ps
module smp_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pins,
  output      logic [WIDTH-1:0] level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } smp_sync_state_t;

  smp_sync_state_t s;
  smp_sync_state_t next_s;

  // first stage feeds only the second
  always_comb begin
    next_s      = s;
    next_s.s1   = pins;
    next_s.s2   = s.s1;
    next_s.s3   = s.s2;
    next_s.filt = (s.s3 & ~(s.s2 ^ s.s3)) | (s.filt & (s.s2 ^ s.s3));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.filt;
endmodule

// >>> hw/smp_device_port.sv
/*
  device end of the scan master host port: strobe-timed register file,
  grant (ready) generation and stall conditions for eight byte registers.
  assumes the scan engine outside supplies buffer flags, the inbound head
  byte and a done pulse, and consumes the write and read pulses.
*/
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module smp_device_port
  import smp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  smp_if.device           bus,
  input  wire logic [7:0] inbound_byte,
  input  wire logic       inbound_empty_flag,
  input  wire logic       outbound_full_flag,
  input  wire logic       counter_status,
  input  wire logic [3:0] tap_state,
  input  wire logic       full_duplex_scan,
  input  wire logic       command_done,
  output      logic [7:0] config_primary,
  output      logic [7:0] config_secondary,
  output      logic [7:0] operation_request,
  output      logic [7:0] manual_pin_control,
  output      logic [7:0] outbound_byte,
  output      logic       outbound_write,
  output      logic       inbound_read,
  output      logic [7:0] cycle_count_byte,
  output      logic       cycle_count_write,
  output      logic       soft_reset
);
  typedef struct packed {
    logic       strobe_low;
    logic       access_read;
    logic [2:0] access_sel;
    logic [7:0] wr_data_hold;
    logic [7:0] cfg_pri;
    logic [7:0] cfg_sec;
    logic [7:0] op_req;
    logic [7:0] out_byte;
    logic [7:0] count;
    logic [7:0] manual;
    logic [3:0] lead;
    logic       grant;
    logic [7:0] dout;
    logic       oe_n;
    logic       out_wr;
    logic       in_rd;
    logic       count_wr;
    logic       soft_rst;
  } smp_dev_state_t;

  smp_dev_state_t s;
  smp_dev_state_t next_s;

  logic       strobe_n_f;
  logic       read_f;
  logic [2:0] sel_f;
  logic [7:0] data_f;
  logic       active;
  logic       fall;
  logic       rise;
  logic       busy;
  logic       lead_counting;
  logic       lookahead_full;
  logic       blocked;
  logic [7:0] flags_value;
  logic [7:0] read_value;

  // every pin passes the filter before touching state
  smp_sync #(
    .WIDTH     (13),
    .RESET_VAL (13'h1000)
  ) u_pin_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pins    ({bus.access_strobe_n, bus.read_select, bus.register_select,
                bus.host_data_bus}),
    .level   ({strobe_n_f, read_f, sel_f, data_f})
  );

  // strobe edges in the core domain
  assign active = !strobe_n_f;
  assign fall   = active && !s.strobe_low;
  assign rise   = !active && s.strobe_low;

  // stall conditions, evaluated on the address caught at the fall
  assign busy           = |s.op_req[SMP_OPCODE_MSB:0];
  assign lead_counting  = full_duplex_scan && (|s.cfg_sec[SMP_RDLY_MSB:0]);
  assign lookahead_full = lead_counting && (s.lead >= SMP_LOOKAHEAD_LIMIT);

  always_comb begin
    blocked = 1'b0;
    if (s.access_read) begin
      blocked = (s.access_sel == SMP_SEL_INBOUND) && inbound_empty_flag;
    end else begin
      unique case (s.access_sel)
        SMP_SEL_OUTBOUND: begin
          blocked = outbound_full_flag || lookahead_full;
        end
        SMP_SEL_CFG_PRI, SMP_SEL_CFG_SEC, SMP_SEL_COUNT: begin
          blocked = busy;
        end
        SMP_SEL_OPREQ: begin
          blocked = busy && !s.wr_data_hold[SMP_SOFT_RESET_BIT];
        end
        SMP_SEL_FLAGS, SMP_SEL_INBOUND, SMP_SEL_MANUAL: begin
          blocked = 1'b0;
        end
      endcase
    end
  end

  // flags: reserved bit 4 reads zero
  assign flags_value = {inbound_empty_flag, outbound_full_flag, counter_status,
                        1'b0, tap_state};

  // read mux over all eight registers
  always_comb begin
    read_value = 8'h00;
    unique case (s.access_sel)
      SMP_SEL_CFG_PRI:  read_value = s.cfg_pri;
      SMP_SEL_CFG_SEC:  read_value = s.cfg_sec;
      SMP_SEL_FLAGS:    read_value = flags_value;
      SMP_SEL_OPREQ:    read_value = s.op_req;
      SMP_SEL_OUTBOUND: read_value = s.out_byte;
      SMP_SEL_INBOUND:  read_value = inbound_byte;
      SMP_SEL_COUNT:    read_value = s.count;
      SMP_SEL_MANUAL:   read_value = s.manual;
    endcase
  end

  // access sequencing, register updates and pulses
  always_comb begin
    next_s            = s;
    next_s.out_wr     = 1'b0;
    next_s.in_rd      = 1'b0;
    next_s.count_wr   = 1'b0;
    next_s.soft_rst   = 1'b0;
    next_s.strobe_low = active;

    // address and direction are caught once, at the fall
    if (fall) begin
      next_s.access_sel  = sel_f;
      next_s.access_read = read_f;
      next_s.grant       = 1'b0;
    end else if (active) begin
      next_s.grant = !blocked;
    end else begin
      next_s.grant = 1'b1;
    end

    // track the bus while low; the value held at the rise is written
    if (active && !s.access_read) begin
      next_s.wr_data_hold = data_f;
    end

    // drive for a read with the strobe low, from the cycle after the fall; load read data only while not blocked
    next_s.oe_n = !(active && !fall && s.access_read);
    if (active && s.access_read && !blocked) begin
      next_s.dout = read_value;
    end

    // engine finishing clears the opcode; a later write may overrule
    if (command_done) begin
      next_s.op_req[SMP_OPCODE_MSB:0] = 4'h0;
    end

    // completion at the rise; an access never granted is dropped
    if (rise && s.grant) begin
      if (s.access_read) begin
        if (s.access_sel == SMP_SEL_INBOUND) begin
          next_s.in_rd = 1'b1;
        end
      end else begin
        unique case (s.access_sel)
          SMP_SEL_CFG_PRI: begin
            next_s.cfg_pri = s.wr_data_hold & SMP_MASK_CFG_PRI;
          end
          SMP_SEL_CFG_SEC: begin
            next_s.cfg_sec = s.wr_data_hold & SMP_MASK_CFG_SEC;
          end
          SMP_SEL_OPREQ: begin
            if (s.wr_data_hold[SMP_SOFT_RESET_BIT]) begin
              next_s.soft_rst = 1'b1;
              next_s.op_req   = SMP_RST_OPREQ;
            end else begin
              next_s.op_req = s.wr_data_hold;
            end
          end
          SMP_SEL_OUTBOUND: begin
            next_s.out_byte = s.wr_data_hold;
            next_s.out_wr   = 1'b1;
          end
          SMP_SEL_COUNT: begin
            next_s.count    = s.wr_data_hold;
            next_s.count_wr = 1'b1;
          end
          SMP_SEL_MANUAL: begin
            if (!busy) begin
              next_s.manual = s.wr_data_hold & SMP_MASK_MANUAL;
            end
          end
          SMP_SEL_FLAGS, SMP_SEL_INBOUND: begin
            next_s.manual = s.manual; // read only, write ignored
          end
        endcase
      end
    end

    // lead of outbound writes over inbound reads, only while it matters
    if (!lead_counting) begin
      next_s.lead = 4'h0;
    end else if (next_s.out_wr && !next_s.in_rd) begin
      next_s.lead = s.lead + 4'h1;
    end else if (next_s.in_rd && !next_s.out_wr && (s.lead != 4'h0)) begin
      next_s.lead = s.lead - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s          <= '0;
      s.cfg_pri  <= SMP_RST_CFG_PRI;
      s.cfg_sec  <= SMP_RST_CFG_SEC;
      s.op_req   <= SMP_RST_OPREQ;
      s.out_byte <= SMP_RST_OUTBOUND;
      s.count    <= SMP_RST_COUNT;
      s.manual   <= SMP_RST_MANUAL;
      s.grant    <= 1'b1;
      s.oe_n     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state
  assign bus.device_data_out  = s.dout;
  assign bus.device_data_oe_n = s.oe_n;
  assign bus.grant            = s.grant;
  assign config_primary       = s.cfg_pri;
  assign config_secondary     = s.cfg_sec;
  assign operation_request    = s.op_req;
  assign manual_pin_control   = s.manual;
  assign outbound_byte        = s.out_byte;
  assign outbound_write       = s.out_wr;
  assign inbound_read         = s.in_rd;
  assign cycle_count_byte     = s.count;
  assign cycle_count_write    = s.count_wr;
  assign soft_reset           = s.soft_rst;
endmodule

// >>> hw/smp_host_master.sv
/*
  host end: runs one strobe access at a time on behalf of software,
  waits on grant, and reports completion and stalls by interrupt.
  assumes software programs target and data before writing go.
*/
`timescale 1ns/10ps
module smp_host_master
  import smp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  smp_if.host             bus,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       write_strobe,
  input  wire logic       read_strobe,
  output      logic [7:0] rdata,
  output      logic       irq
);
  typedef enum logic [2:0] {
    SMP_IDLE    = 3'b000,
    SMP_SETUP   = 3'b001,
    SMP_LOW     = 3'b010,
    SMP_WAIT    = 3'b011,
    SMP_HOLD    = 3'b100,
    SMP_RECOVER = 3'b101
  } smp_host_fsm_t;

  typedef struct packed {
    smp_host_fsm_t fsm;
    logic [3:0]    timer;
    logic [7:0]    target;
    logic [7:0]    wbyte;
    logic [7:0]    result;
    logic          stall_seen;
    logic [1:0]    irq_stat;
    logic [1:0]    irq_mask;
    logic [7:0]    rdata;
    logic          strobe_n;
    logic          rd_sel;
    logic [2:0]    sel;
    logic [7:0]    dout;
    logic          oe_n;
  } smp_host_state_t;

  smp_host_state_t s;
  smp_host_state_t next_s;

  logic       grant_f;
  logic [7:0] data_f;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  // grant and bus come from the far side, so they are filtered
  smp_sync #(
    .WIDTH     (9),
    .RESET_VAL (9'h1FF)
  ) u_pin_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pins    ({bus.grant, bus.host_data_bus}),
    .level   ({grant_f, data_f})
  );

  always_comb begin
    next_s  = s;
    irq_set = 2'b00;
    irq_clr = 2'b00;

    // software port; read data stands the cycle after the strobe
    if (write_strobe) begin
      unique case (addr)
        SMP_H_TARGET:   next_s.target = wdata;
        SMP_H_WDATA:    next_s.wbyte = wdata;
        SMP_H_IRQ_STAT: irq_clr = wdata[1:0];
        SMP_H_IRQ_MASK: next_s.irq_mask = wdata[1:0];
        default:        next_s.target = s.target;
      endcase
    end
    next_s.rdata = 8'h00;
    if (read_strobe) begin
      unique case (addr)
        SMP_H_TARGET:   next_s.rdata = s.target;
        SMP_H_WDATA:    next_s.rdata = s.wbyte;
        SMP_H_RDATA:    next_s.rdata = s.result;
        SMP_H_STATUS:   next_s.rdata = {6'h00, s.stall_seen, s.fsm != SMP_IDLE};
        SMP_H_IRQ_STAT: next_s.rdata = {6'h00, s.irq_stat};
        SMP_H_IRQ_MASK: next_s.rdata = {6'h00, s.irq_mask};
        default:        next_s.rdata = 8'h00;
      endcase
    end

    // strobe sequencer; select and direction stay put throughout
    unique case (s.fsm)
      SMP_IDLE: begin
        if (write_strobe && (addr == SMP_H_GO)) begin
          next_s.sel        = s.target[2:0];
          next_s.rd_sel     = s.target[SMP_HOST_READ_BIT];
          next_s.dout       = s.wbyte;
          next_s.oe_n       = s.target[SMP_HOST_READ_BIT];
          next_s.stall_seen = 1'b0;
          next_s.timer      = 4'(SMP_SETUP_CYC - 1);
          next_s.fsm        = SMP_SETUP;
        end
      end
      SMP_SETUP: begin
        next_s.timer = s.timer - 4'h1;
        if (s.timer == 4'h0) begin
          next_s.strobe_n = 1'b0;
          next_s.timer    = 4'(SMP_LOW_CYC - 1);
          next_s.fsm      = SMP_LOW;
        end
      end
      SMP_LOW: begin
        next_s.timer = s.timer - 4'h1;
        if (s.timer == 4'h0) begin
          next_s.fsm = SMP_WAIT;
        end
      end
      SMP_WAIT: begin
        if (grant_f) begin
          if (s.rd_sel) begin
            next_s.result = data_f;
          end
          next_s.strobe_n = 1'b1;
          next_s.timer    = 4'(SMP_HOLD_CYC - 1);
          next_s.fsm      = SMP_HOLD;
        end else if (!s.stall_seen) begin
          next_s.stall_seen = 1'b1;
          irq_set[SMP_IRQ_STALL_BIT] = 1'b1;
        end
      end
      SMP_HOLD: begin
        next_s.timer = s.timer - 4'h1;
        if (s.timer == 4'h0) begin
          next_s.oe_n  = 1'b1;
          next_s.timer = 4'(SMP_RECOVER_CYC - 1);
          next_s.fsm   = SMP_RECOVER;
        end
      end
      SMP_RECOVER: begin
        next_s.timer = s.timer - 4'h1;
        if (s.timer == 4'h0) begin
          irq_set[SMP_IRQ_DONE_BIT] = 1'b1;
          next_s.fsm = SMP_IDLE;
        end
      end
      default: begin
        next_s.fsm = SMP_IDLE;
      end
    endcase

    // a new event beats a clear in the same cycle
    next_s.irq_stat = (s.irq_stat & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s          <= '0;
      s.fsm      <= SMP_IDLE;
      s.strobe_n <= 1'b1;
      s.oe_n     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign bus.access_strobe_n = s.strobe_n;
  assign bus.read_select     = s.rd_sel;
  assign bus.register_select = s.sel;
  assign bus.host_data_out   = s.dout;
  assign bus.host_data_oe_n  = s.oe_n;
  assign rdata               = s.rdata;
  assign irq                 = |(s.irq_stat & s.irq_mask);
endmodule

// >>> verification/smp_link_monitor.sv
/*
  concurrent checks on the pins between host end and device end.
  assumes both ends share clk and the active-low reset.
*/
`timescale 1ns/10ps
module smp_link_monitor
  import smp_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       access_strobe_n,
  input wire logic       read_select,
  input wire logic [2:0] register_select,
  input wire logic [7:0] host_data_out,
  input wire logic       host_data_oe_n,
  input wire logic [7:0] device_data_out,
  input wire logic       device_data_oe_n,
  input wire logic       grant,
  input wire logic [7:0] host_data_bus
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // direction and drive of the shared bus
  write_release_a: assert property (!access_strobe_n && !read_select |-> device_data_oe_n)
    else $error("device drove bus in a write");
  read_drive_a: assert property ($fell(access_strobe_n) && read_select
    |-> ##[1:8] !device_data_oe_n)
    else $error("device never drove a read");
  idle_release_a: assert property (access_strobe_n [*8] |-> device_data_oe_n)
    else $error("device drove bus while strobe high");
  no_clash_a: assert property (!(!host_data_oe_n && !device_data_oe_n))
    else $error("both ends drive the bus");
  write_drive_a: assert property (!access_strobe_n && !read_select |-> !host_data_oe_n)
    else $error("host left write data undriven");
  // grant follows the strobe; an access ends only when granted
  grant_drop_a: assert property ($fell(access_strobe_n) |-> ##[1:8] !grant)
    else $error("grant did not drop on access");
  grant_idle_a: assert property (access_strobe_n [*8] |-> grant)
    else $error("grant low while idle");
  end_granted_a: assert property ($rose(access_strobe_n)
    |-> $past(grant, 1) && $past(grant, 2))
    else $error("access ended without grant");
  select_hold_a: assert property (!access_strobe_n && !$past(access_strobe_n)
    |-> $stable(register_select) && $stable(read_select))
    else $error("select moved while strobe low");
  // reserved bits read as zero once the read data have settled
  manual_rsvd_a: assert property (
    (!device_data_oe_n && grant && register_select == SMP_SEL_MANUAL) [*2]
    |-> device_data_out[7:4] == 4'h0)
    else $error("manual reserved bits not zero");

  cover property ($fell(access_strobe_n) && read_select);
  cover property ($fell(access_strobe_n) && !read_select);
  cover property ((!access_strobe_n && !grant) [*8]);
  cover property ($rose(access_strobe_n) && !read_select && host_data_bus == host_data_out);
endmodule

// >>> verification/testbench.sv
/*
  bench for both ends, driven through the software port of the host end.
  assumes engine-side inputs of the device end are plain bench registers.
*/
`timescale 1ns/10ps
module testbench
  import smp_pkg::*;
;
  logic       clk, reset_n = 1'b0, write_strobe = 1'b0, read_strobe = 1'b0, irq;
  logic       in_empty = 1'b0, out_full = 1'b0, ctr_stat = 1'b1, full_dup = 1'b0, cmd_done = 1'b0;
  logic       out_wr, in_rd, soft_rst, cnt_wr;
  logic [2:0] addr = 3'h0;
  logic [3:0] tap_st = 4'h9;
  logic [7:0] wdata = 8'h00, in_byte = 8'h5C, rdata, cfg_pri, op_req, out_byte, cnt_byte, got;
  logic [7:0] cfg_sec, man_pins;
  logic [7:0] tab [8];
  int         n_fail = 0, tests_run = 0, cycles = 0, n_out = 0, n_in = 0, n_sr = 0, n_cw = 0;

  smp_if u_smp_if ();
  smp_host_master u_smp_host_master (.clk(clk), .reset_n(reset_n), .bus(u_smp_if.host),
    .addr(addr), .wdata(wdata), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .rdata(rdata), .irq(irq));
  smp_device_port u_smp_device_port (.clk(clk), .reset_n(reset_n), .bus(u_smp_if.device),
    .inbound_byte(in_byte), .inbound_empty_flag(in_empty), .outbound_full_flag(out_full),
    .counter_status(ctr_stat), .tap_state(tap_st), .full_duplex_scan(full_dup),
    .command_done(cmd_done), .config_primary(cfg_pri), .config_secondary(cfg_sec),
    .operation_request(op_req), .manual_pin_control(man_pins), .outbound_byte(out_byte),
    .outbound_write(out_wr), .inbound_read(in_rd), .cycle_count_byte(cnt_byte),
    .cycle_count_write(cnt_wr), .soft_reset(soft_rst));
  smp_link_monitor u_smp_link_monitor (.clk(clk), .reset_n(reset_n),
    .access_strobe_n(u_smp_if.access_strobe_n), .read_select(u_smp_if.read_select),
    .register_select(u_smp_if.register_select), .host_data_out(u_smp_if.host_data_out),
    .host_data_oe_n(u_smp_if.host_data_oe_n), .device_data_out(u_smp_if.device_data_out),
    .device_data_oe_n(u_smp_if.device_data_oe_n), .grant(u_smp_if.grant),
    .host_data_bus(u_smp_if.host_data_bus));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // engine-side pulse tallies and a hang limit well above the expected run
  always @(posedge clk) begin
    cycles++;
    if (out_wr === 1'b1) n_out++;
    if (in_rd === 1'b1) n_in++;
    if (soft_rst === 1'b1) n_sr++;
    if (cnt_wr === 1'b1) n_cw++;
    if (cycles == 40000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // software port: one-cycle strobes, read data in the following cycle
  task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
  endtask

  task automatic sw_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // one link access: target, data, go; completion seen on the done interrupt
  task automatic start(input logic rd, input logic [2:0] s, input logic [7:0] d);
    sw_wr(SMP_H_TARGET, {rd, 4'h0, s});
    sw_wr(SMP_H_WDATA, d);
    sw_wr(SMP_H_GO, 8'h01);
  endtask

  task automatic finish();
    for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge clk);
    chk("irq_done", 8'h01, {7'h00, irq});
    sw_wr(SMP_H_IRQ_STAT, 8'h03);
    repeat (2) @(posedge clk);
    chk("irq_clear", 8'h00, {7'h00, irq});
  endtask

  task automatic rd_link(input logic [2:0] s, input logic [7:0] e);
    start(1'b1, s, 8'h00);
    finish();
    sw_rd(SMP_H_RDATA, got);
    chk("link_read", e, got);
  endtask

  task automatic wr_link(input logic [2:0] s, input logic [7:0] d);
    start(1'b0, s, d);
    finish();
  endtask

  // a stalled access keeps grant low and raises no completion
  task automatic stall_chk();
    repeat (40) @(posedge clk);
    chk("grant", 8'h00, {7'h00, u_smp_if.grant});
    chk("irq_idle", 8'h00, {7'h00, irq});
    sw_rd(SMP_H_STATUS, got);
    chk("status", 8'h03, got);
    sw_rd(SMP_H_IRQ_STAT, got);
    chk("irq_stat", 8'h02, got);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    sw_wr(SMP_H_IRQ_MASK, 8'h01);
    // reset values, then writes with reserved bits clear; read-only places ignore writes
    tab = '{8'h00, 8'h80, 8'h29, 8'h00, 8'h00, 8'h5C, 8'h00, 8'h00};
    for (int k = 0; k < 8; k++) rd_link(k[2:0], tab[k]);
    tab = '{8'h32, 8'hE5, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h0A};
    for (int k = 0; k < 8; k++) if (k != 3 && k != 4) wr_link(k[2:0], tab[k]);
    tab = '{8'h32, 8'hE5, 8'h29, 8'h00, 8'h00, 8'h5C, 8'hFF, 8'h0A};
    for (int k = 0; k < 8; k++) rd_link(k[2:0], tab[k]);
    chk("count_out", 8'hFF, cnt_byte);
    chk("cfg_sec_out", 8'hE5, cfg_sec);
    chk("manual_out", 8'h0A, man_pins);
    chk("count_wr", 8'h01, n_cw[7:0]);
    // busy opcode: config write waits for the command to finish
    wr_link(SMP_SEL_OPREQ, 8'h05);
    start(1'b0, SMP_SEL_CFG_PRI, 8'h11);
    stall_chk();
    chk("cfg_hold", 8'h32, cfg_pri);
    @(posedge clk) cmd_done <= 1'b1;
    @(posedge clk) cmd_done <= 1'b0;
    finish();
    chk("cfg_pri", 8'h11, cfg_pri);
    chk("opcode", 8'h00, {4'h0, op_req[3:0]});
    // busy again: manual write dropped, soft reset never held
    wr_link(SMP_SEL_OPREQ, 8'h03);
    wr_link(SMP_SEL_MANUAL, 8'h03);
    rd_link(SMP_SEL_MANUAL, 8'h0A);
    wr_link(SMP_SEL_OPREQ, 8'h80);
    chk("op_req", 8'h00, op_req);
    chk("soft_rst", 8'h01, n_sr[7:0]);
    // empty inbound buffer holds a read until data arrive
    @(posedge clk) in_empty <= 1'b1;
    rd_link(SMP_SEL_FLAGS, 8'hA9);
    start(1'b1, SMP_SEL_INBOUND, 8'h00);
    stall_chk();
    @(posedge clk) in_empty <= 1'b0;
    finish();
    sw_rd(SMP_H_RDATA, got);
    chk("in_byte", 8'h5C, got);
    chk("pops", 8'h03, n_in[7:0]);
    // full outbound buffer holds a write
    @(posedge clk) out_full <= 1'b1;
    rd_link(SMP_SEL_FLAGS, 8'h69);
    start(1'b0, SMP_SEL_OUTBOUND, 8'hA5);
    stall_chk();
    chk("no_push", 8'h00, n_out[7:0]);
    @(posedge clk) out_full <= 1'b0;
    finish();
    chk("out_byte", 8'hA5, out_byte);
    // lead of five writes over reads; a read makes room for one more
    @(posedge clk) full_dup <= 1'b1;
    for (int k = 0; k < 5; k++) wr_link(SMP_SEL_OUTBOUND, k[7:0]);
    rd_link(SMP_SEL_INBOUND, 8'h5C);
    wr_link(SMP_SEL_OUTBOUND, 8'h55);
    start(1'b0, SMP_SEL_OUTBOUND, 8'h66);
    stall_chk();
    chk("pushes", 8'h07, n_out[7:0]);
    @(posedge clk) full_dup <= 1'b0;
    finish();
    chk("out_byte", 8'h66, out_byte);
    // masked completion stays quiet until unmasked
    sw_wr(SMP_H_IRQ_MASK, 8'h00);
    start(1'b1, SMP_SEL_CFG_PRI, 8'h00);
    repeat (100) @(posedge clk);
    chk("irq_masked", 8'h00, {7'h00, irq});
    sw_wr(SMP_H_IRQ_MASK, 8'h01);
    finish();
    // second reset in mid-run restores reset values
    @(posedge clk) reset_n <= 1'b0;
    repeat (16) @(posedge clk);
    chk("rst_cfg", 8'h00, cfg_pri);
    reset_n <= 1'b1;
    sw_wr(SMP_H_IRQ_MASK, 8'h01);
    rd_link(SMP_SEL_CFG_SEC, 8'h80);
    print_verdict();
  end
endmodule
